// [logic/aec_fifo2.sv]
// aec_fifo2: two-entry valid/ready buffer for injected ADM bytes
`timescale 1ns/10ps
module aec_fifo2
  import aec_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  input  wire logic                 in_valid_in,
  output      logic                 in_ready_out,
  input  wire logic [INJ_WIDTH-1:0] in_data_in,
  output      logic                 out_valid_out,
  input  wire logic                 out_ready_in,
  output      logic [INJ_WIDTH-1:0] out_data_out
);

  typedef struct packed {
    logic [INJ_DEPTH-1:0][INJ_WIDTH-1:0] mem;
    logic                                rd_ptr;
    logic                                wr_ptr;
    logic [1:0]                          count;
  } aec_fifo_type;

  aec_fifo_type st_r;
  aec_fifo_type st_nxt;
  logic         push;
  logic         pop;

  assign in_ready_out  = (st_r.count != 2'(INJ_DEPTH));
  assign out_valid_out = (st_r.count != 2'h0);
  assign out_data_out  = st_r.mem[st_r.rd_ptr];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr_ptr] = in_data_in;
      st_nxt.wr_ptr           = ~st_r.wr_ptr;
    end
    if (pop) begin
      st_nxt.rd_ptr = ~st_r.rd_ptr;
    end
    st_nxt.count = st_r.count + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // aec_fifo2

// [logic/aec_pkg.sv]
// aec_pkg: constants and tables for the encoder configuration block
//------------------------------------------------------------
//------------------------------------------------------------
package aec_pkg;

  // register addresses on the serial control bus
  localparam logic [7:0] ADDR_ADM_PARAMS    = 8'hE1;
  localparam logic [7:0] ADDR_VOICE_THRESH  = 8'hE2;
  localparam logic [7:0] ADDR_OFFSET_TRIM   = 8'hE3;
  localparam logic [7:0] ADDR_DAC_DIRECT    = 8'hE7;
  localparam logic [7:0] ADDR_ADM_INJECT    = 8'hE8;

  // frame lengths in serial bits, address byte included
  localparam logic [4:0] FRAME_BITS_ADDR    = 5'h08;
  localparam logic [4:0] FRAME_BITS_BYTE    = 5'h10;
  localparam logic [4:0] FRAME_BITS_WORD    = 5'h18;

  // field positions of encoder_adm_params
  localparam int SYL_MSB   = 15;
  localparam int SYL_LSB   = 13;
  localparam int STEP_MSB  = 12;
  localparam int STEP_LSB  = 10;
  localparam int RUN_MSB   = 9;
  localparam int RUN_LSB   = 8;
  localparam int EST_MSB   = 7;
  localparam int EST_LSB   = 5;
  localparam int SO_MSB    = 4;
  localparam int SO_LSB    = 3;
  localparam int ZERO_MSB  = 2;
  localparam int ZERO_LSB  = 1;
  localparam int HALF_BIT  = 0;

  // reset values
  localparam logic [15:0] RST_ADM_PARAMS   = 16'h0000;
  localparam logic [15:0] RST_VOICE_THRESH = 16'h0000;
  localparam logic [15:0] RST_OFFSET_TRIM  = 16'h0000;
  localparam logic [15:0] RST_DAC_DIRECT   = 16'h0000;
  localparam logic [15:0] RST_STEP         = 16'h0014;
  localparam logic [14:0] VOICE_THRESH_MAX = 15'h7FFF;

  // time-constant numerators, divided by 3*bit rate downstream
  localparam logic [12:0] SYL_N_TAB [8] = '{13'h0200, 13'h0300, 13'h0400, 13'h0600,
                                            13'h0800, 13'h0C00, 13'h1000, 13'h1800};
  localparam logic [7:0]  EST_N_TAB [8] = '{8'h10, 8'h18, 8'h20, 8'h30,
                                            8'h40, 8'h60, 8'h80, 8'hC0};
  localparam logic [15:0] MAX_STEP_TAB [4] = '{16'h2800, 16'h1400, 16'h0A00, 16'h0500};
  localparam logic [15:0] MIN_STEP_WIDE    = 16'h0014;
  localparam logic [15:0] MIN_STEP_NARROW  = 16'h000A;
  localparam logic [2:0]  RUN_LEN_TAB [4]  = '{3'h3, 3'h4, 3'h5, 3'h6};
  // zero time constants in tenths of ms*kbps (1.5, 2.5, 4.5)
  localparam logic [5:0]  ZERO_TC_TAB [4]  = '{6'h00, 6'h0F, 6'h19, 6'h2D};

  // step adaptation shifts
  localparam int STEP_GROW_SHIFT  = 5;
  localparam int STEP_DECAY_BASE  = 5;

  // inject buffer shape
  localparam int INJ_WIDTH = 8;
  localparam int INJ_DEPTH = 2;

endpackage : aec_pkg

// [logic/aec_top.sv]
// aec_top: serial-bus register file and encoder configuration logic
`timescale 1ns/10ps
module aec_top
  import aec_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // serial control bus pins
  input  wire logic        bus_clk_in,
  input  wire logic        bus_sel_n_in,
  input  wire logic        bus_data_in,
  // encoder side, same clock
  input  wire logic        bit_tick_in,
  input  wire logic        adm_bit_in,
  input  wire logic        adm_decode_in,
  input  wire logic        idle_enhance_in,
  input  wire logic        inject_irq_en_in,
  input  wire logic        sample_valid_in,
  input  wire logic [15:0] sample_in,
  // decoded settings
  output      logic [12:0] syllabic_n_out,
  output      logic [15:0] max_step_out,
  output      logic [15:0] min_step_out,
  output      logic [2:0]  run_len_out,
  output      logic [7:0]  estimator_n_out,
  output      logic        second_order_out,
  output      logic [1:0]  second_order_shift_out,
  output      logic        zero_en_out,
  output      logic [5:0]  zero_tc_out,
  output      logic        half_rate_zero_out,
  output      logic [14:0] voice_threshold_out,
  output      logic [15:0] dac_direct_out,
  output      logic        dac_direct_strobe_out,
  // encoder datapath
  output      logic [15:0] step_out,
  output      logic [15:0] enc_sum_out,
  output      logic        enc_sum_valid_out,
  output      logic [15:0] offset_estimate_out,
  output      logic        inject_bit_out,
  output      logic        inject_valid_out,
  output      logic        inject_ready_out,
  output      logic        irq_n_out
);

  typedef struct packed {
    // pin synchronisers: [2]=clock, [1]=select, [0]=data
    logic [2:0]  sy1;
    logic [2:0]  sy2;
    logic [2:0]  sy3;
    logic [2:0]  pin;
    logic [23:0] shf;
    logic [4:0]  bcnt;
    logic [15:0] adm_params;
    logic [15:0] voice_thresh;
    logic [15:0] offset_trim;
    logic [15:0] dac_direct;
    logic        dac_strobe;
    logic        inj_wr;
    logic [7:0]  inj_byte;
    logic [12:0] syl_n;
    logic [15:0] max_step;
    logic [15:0] min_step;
    logic [2:0]  run_len;
    logic [7:0]  est_n;
    logic        so_en;
    logic [1:0]  so_shift;
    logic        zero_en;
    logic [5:0]  zero_tc;
    logic        half_zero;
    logic [15:0] step;
    logic [2:0]  run_cnt;
    logic        last_bit;
    logic [15:0] est;
    logic [15:0] sum;
    logic        sum_valid;
    logic [7:0]  inj_shift;
    logic [3:0]  inj_cnt;
    logic        inj_bit;
    logic        inj_valid;
    logic        inj_room;
    logic        irq_n;
  } aec_state_type;

  aec_state_type st_r;
  aec_state_type st_nxt;

  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic       fifo_pop;

  //------------------------------------------------------------
  // inject buffer
  //------------------------------------------------------------
  // the serialiser pulls a byte only when its own shifter is spent,
  // so the buffer really fills and the ready flag means something
  assign fifo_pop = (st_r.inj_cnt == 4'h0);

  aec_fifo2 u_inject_fifo (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (st_r.inj_wr),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (st_r.inj_byte),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    logic        clk_rise;
    logic        sel_fall;
    logic [23:0] shf_new;
    logic [4:0]  cnt_new;
    logic [7:0]  addr;
    logic [17:0] wide;
    logic [15:0] grown;
    logic [15:0] decayed;
    logic [2:0]  run_new;
    logic [1:0]  so_code;
    logic [1:0]  zero_code;
    clk_rise  = 1'b0;
    sel_fall  = 1'b0;
    shf_new   = '0;
    cnt_new   = '0;
    addr      = '0;
    wide      = '0;
    grown     = '0;
    decayed   = '0;
    run_new   = '0;
    so_code   = '0;
    zero_code = '0;
    st_nxt    = st_r;

    // pins settle once the second and third stages agree
    st_nxt.sy1 = {bus_clk_in, bus_sel_n_in, bus_data_in};
    st_nxt.sy2 = st_r.sy1;
    st_nxt.sy3 = st_r.sy2;
    for (int i = 0; i < 3; i++) begin
      if (st_r.sy2[i] == st_r.sy3[i]) begin
        st_nxt.pin[i] = st_r.sy3[i];
      end
    end
    clk_rise = st_nxt.pin[2] & ~st_r.pin[2];
    sel_fall = ~st_nxt.pin[1] & st_r.pin[1];

    //------------------------------------------------------------
    // serial frame: address byte then one or two data bytes, msb first
    //------------------------------------------------------------
    st_nxt.dac_strobe = 1'b0;
    st_nxt.inj_wr     = 1'b0;
    if (sel_fall || st_nxt.pin[1]) begin
      st_nxt.bcnt = '0;
    end else if (clk_rise && st_r.bcnt != FRAME_BITS_WORD) begin
      shf_new     = {st_r.shf[22:0], st_nxt.pin[0]};
      cnt_new     = st_r.bcnt + 5'h01;
      st_nxt.shf  = shf_new;
      st_nxt.bcnt = cnt_new;
      addr        = (cnt_new == FRAME_BITS_WORD) ? shf_new[23:16] : shf_new[15:8];
      if (cnt_new == FRAME_BITS_WORD) begin
        unique case (addr)
          ADDR_ADM_PARAMS:   st_nxt.adm_params   = shf_new[15:0];
          ADDR_VOICE_THRESH: st_nxt.voice_thresh = shf_new[15:0];
          ADDR_OFFSET_TRIM:  st_nxt.offset_trim  = shf_new[15:0];
          ADDR_DAC_DIRECT: begin
            st_nxt.dac_direct = shf_new[15:0];
            st_nxt.dac_strobe = 1'b1;
          end
          default: ;
        endcase
      end else if (cnt_new == FRAME_BITS_BYTE && addr == ADDR_ADM_INJECT) begin
        // one-byte frame ends here; a full buffer drops the byte
        st_nxt.inj_wr   = 1'b1;
        st_nxt.inj_byte = shf_new[7:0];
        st_nxt.bcnt     = FRAME_BITS_WORD;
      end
    end

    //------------------------------------------------------------
    // decode of the adm parameter word
    //------------------------------------------------------------
    st_nxt.syl_n    = SYL_N_TAB[st_r.adm_params[SYL_MSB:SYL_LSB]];
    st_nxt.max_step = MAX_STEP_TAB[st_r.adm_params[STEP_MSB:STEP_LSB+1]];
    st_nxt.min_step = st_r.adm_params[STEP_LSB] ? MIN_STEP_NARROW : MIN_STEP_WIDE;
    st_nxt.run_len  = RUN_LEN_TAB[st_r.adm_params[RUN_MSB:RUN_LSB]];
    st_nxt.est_n    = EST_N_TAB[st_r.adm_params[EST_MSB:EST_LSB]];
    so_code         = st_r.adm_params[SO_MSB:SO_LSB];
    zero_code       = st_r.adm_params[ZERO_MSB:ZERO_LSB];
    st_nxt.so_en    = (so_code != 2'h0);
    st_nxt.so_shift = so_code;
    // the zero only helps a second-order loop, so first order masks it
    st_nxt.zero_en  = (zero_code != 2'h0) && (so_code != 2'h0);
    st_nxt.zero_tc  = st_nxt.zero_en ? ZERO_TC_TAB[zero_code] : 6'h00;
    // gated by decode so a stray setting cannot upset the encode loop
    st_nxt.half_zero = st_r.adm_params[HALF_BIT] & adm_decode_in;

    //------------------------------------------------------------
    // step-size adaptation
    //------------------------------------------------------------
    if (bit_tick_in) begin
      run_new = (adm_bit_in == st_r.last_bit) ?
                ((st_r.run_cnt == 3'h7) ? 3'h7 : st_r.run_cnt + 3'h1) : 3'h1;
      st_nxt.run_cnt  = run_new;
      st_nxt.last_bit = adm_bit_in;
      grown   = st_r.step + (st_r.max_step >> STEP_GROW_SHIFT);
      decayed = st_r.step
              - (st_r.step >> (STEP_DECAY_BASE + int'(st_r.adm_params[SYL_MSB:SYL_LSB])));
      st_nxt.step = (run_new >= st_r.run_len) ? grown : decayed;
      if (st_nxt.step > st_r.max_step) begin
        st_nxt.step = st_r.max_step;
      end else if (st_nxt.step < st_r.min_step) begin
        st_nxt.step = st_r.min_step;
      end
    end

    //------------------------------------------------------------
    // offset trim and automatic compensation
    //------------------------------------------------------------
    st_nxt.sum_valid = sample_valid_in;
    if (sample_valid_in) begin
      wide = {{2{sample_in[15]}}, sample_in}
           + {{2{st_r.offset_trim[15]}}, st_r.offset_trim}
           + (idle_enhance_in ? {{2{st_r.est[15]}}, st_r.est} : 18'h00000);
      if ($signed(wide) > 18'sh07FFF) begin
        st_nxt.sum = 16'h7FFF;
      end else if ($signed(wide) < -18'sh08000) begin
        st_nxt.sum = 16'h8000;
      end else begin
        st_nxt.sum = wide[15:0];
      end
      // estimate walks against the sign of the output; a zero trim freezes it
      if (idle_enhance_in && st_r.offset_trim != 16'h0000) begin
        if (st_nxt.sum[15] && st_r.est != 16'h7FFF) begin
          st_nxt.est = st_r.est + 16'h0001;
        end else if (!st_nxt.sum[15] && st_nxt.sum != 16'h0000 && st_r.est != 16'h8000) begin
          st_nxt.est = st_r.est - 16'h0001;
        end
      end
    end

    //------------------------------------------------------------
    // injected bit serialiser
    //------------------------------------------------------------
    if (fifo_pop && fifo_out_valid) begin
      st_nxt.inj_shift = fifo_out_data;
      st_nxt.inj_cnt   = 4'h8;
    end else if (bit_tick_in && st_r.inj_cnt != 4'h0) begin
      st_nxt.inj_bit   = st_r.inj_shift[7];
      st_nxt.inj_shift = {st_r.inj_shift[6:0], 1'b0};
      st_nxt.inj_cnt   = st_r.inj_cnt - 4'h1;
    end
    // valid marks the bit period after a real bit; an underrun drops it
    if (bit_tick_in) begin
      st_nxt.inj_valid = (st_r.inj_cnt != 4'h0);
    end
    st_nxt.inj_room = fifo_in_ready;
    st_nxt.irq_n    = ~(inject_irq_en_in & fifo_in_ready);
  end

  //------------------------------------------------------------
  // state register
  //------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r              <= '0;
      st_r.sy1          <= 3'h6;
      st_r.sy2          <= 3'h6;
      st_r.sy3          <= 3'h6;
      st_r.pin          <= 3'h6;
      st_r.adm_params   <= RST_ADM_PARAMS;
      st_r.voice_thresh <= RST_VOICE_THRESH;
      st_r.offset_trim  <= RST_OFFSET_TRIM;
      st_r.dac_direct   <= RST_DAC_DIRECT;
      st_r.syl_n        <= SYL_N_TAB[0];
      st_r.max_step     <= MAX_STEP_TAB[0];
      st_r.min_step     <= MIN_STEP_WIDE;
      st_r.run_len      <= RUN_LEN_TAB[0];
      st_r.est_n        <= EST_N_TAB[0];
      st_r.step         <= RST_STEP;
      st_r.irq_n        <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  assign syllabic_n_out         = st_r.syl_n;
  assign max_step_out           = st_r.max_step;
  assign min_step_out           = st_r.min_step;
  assign run_len_out            = st_r.run_len;
  assign estimator_n_out        = st_r.est_n;
  assign second_order_out       = st_r.so_en;
  assign second_order_shift_out = st_r.so_shift;
  assign zero_en_out            = st_r.zero_en;
  assign zero_tc_out            = st_r.zero_tc;
  assign half_rate_zero_out     = st_r.half_zero;
  // top bit ignored: the threshold is never negative
  assign voice_threshold_out    = st_r.voice_thresh[14:0] & VOICE_THRESH_MAX;
  assign dac_direct_out         = st_r.dac_direct;
  assign dac_direct_strobe_out  = st_r.dac_strobe;
  assign step_out               = st_r.step;
  assign enc_sum_out            = st_r.sum;
  assign enc_sum_valid_out      = st_r.sum_valid;
  assign offset_estimate_out    = st_r.est;
  assign inject_bit_out         = st_r.inj_bit;
  assign inject_valid_out       = st_r.inj_valid;
  assign inject_ready_out       = st_r.inj_room;
  assign irq_n_out              = st_r.irq_n;

endmodule // aec_top

// [tb/aec_assertions.sv]
// aec_assertions: port-level checks bound to aec_top
`timescale 1ns/10ps
module aec_assertions (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        bit_tick_in,
  input wire logic        adm_decode_in,
  input wire logic        idle_enhance_in,
  input wire logic        inject_irq_en_in,
  input wire logic        sample_valid_in,
  input wire logic [15:0] max_step_out,
  input wire logic [15:0] min_step_out,
  input wire logic        second_order_out,
  input wire logic [1:0]  second_order_shift_out,
  input wire logic        zero_en_out,
  input wire logic [5:0]  zero_tc_out,
  input wire logic        half_rate_zero_out,
  input wire logic [15:0] step_out,
  input wire logic        enc_sum_valid_out,
  input wire logic [15:0] offset_estimate_out,
  input wire logic        inject_valid_out,
  input wire logic        irq_n_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  step_clamp_a: assert property (
    bit_tick_in |=> step_out <= max_step_out && step_out >= min_step_out)
    else $error("step outside limits");
  step_min_a: assert property (min_step_out inside {16'h0014, 16'h000A})
    else $error("bad minimum step");
  order_sel_a: assert property (second_order_out == (second_order_shift_out != 2'h0))
    else $error("order flag mismatch");
  zero_sel_a: assert property (
    zero_en_out == (zero_tc_out != 6'h00) && (!zero_en_out || second_order_out))
    else $error("zero flag mismatch");
  half_zero_a: assert property (half_rate_zero_out |-> $past(adm_decode_in))
    else $error("half-rate zero while encoding");
  sum_pulse_a: assert property (
    sample_valid_in |=> enc_sum_valid_out ##1 !enc_sum_valid_out)
    else $error("sum valid timing");
  est_frozen_a: assert property (
    !$past(idle_enhance_in) |-> $stable(offset_estimate_out))
    else $error("estimate moved without enhance");
  inject_hold_a: assert property (!$past(bit_tick_in) |-> $stable(inject_valid_out))
    else $error("inject valid moved off tick");
  irq_mask_a: assert property (!irq_n_out |-> $past(inject_irq_en_in))
    else $error("interrupt while disabled");
endmodule // aec_assertions
bind aec_top aec_assertions u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .bit_tick_in(bit_tick_in), .adm_decode_in(adm_decode_in),
  .idle_enhance_in(idle_enhance_in), .inject_irq_en_in(inject_irq_en_in),
  .sample_valid_in(sample_valid_in), .max_step_out(max_step_out),
  .min_step_out(min_step_out), .second_order_out(second_order_out),
  .second_order_shift_out(second_order_shift_out), .zero_en_out(zero_en_out),
  .zero_tc_out(zero_tc_out), .half_rate_zero_out(half_rate_zero_out),
  .step_out(step_out), .enc_sum_valid_out(enc_sum_valid_out),
  .offset_estimate_out(offset_estimate_out), .inject_valid_out(inject_valid_out),
  .irq_n_out(irq_n_out));

// [tb/aec_host_model.sv]
// aec_host_model: host side of the serial control bus
`timescale 1ns/10ps
module aec_host_model (
  input  wire logic clk_in,
  output      logic bclk_out,
  output      logic bsel_n_out,
  output      logic bdat_out
);
  // bus clock stands high between frames; 5 clk_in a phase outruns the sync
  initial begin
    bclk_out   = 1'b1;
    bsel_n_out = 1'b1;
    bdat_out   = 1'b0;
  end
  task automatic half_bit();
    repeat (5) @(posedge clk_in);
    #2;
  endtask
  task automatic shift_out(input logic [23:0] bits, input int n);
    bsel_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      bclk_out = 1'b0;
      bdat_out = bits[23-i];
      half_bit();
      bclk_out = 1'b1;
      half_bit();
    end
    bsel_n_out = 1'b1;
    bdat_out   = ~bdat_out; // a released line must not keep the last bit
    half_bit();
    half_bit();
  endtask
  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    shift_out({a, d}, 24);
  endtask
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    shift_out({a, d, 8'h00}, 16);
  endtask
endmodule // aec_host_model

// [tb/aec_top_tb_top.sv]
// aec_top_tb_top: directed register and stream tests for aec_top
`timescale 1ns/10ps
module aec_top_tb_top;
  import aec_pkg::*;
  logic        clk_in, nrst_in, bclk, bsel_n, bdat, tick, adm_bit, dec, enh, irq_en, sv;
  logic [15:0] smp, mx, mn, stp, sum, est, dac;
  logic [12:0] syl_n;
  logic [7:0]  est_n;
  logic [2:0]  run;
  logic [1:0]  shf;
  logic [5:0]  ztc;
  logic [14:0] vth;
  logic        so, zen, hrz, dstb, sumv, ibit, ival, irdy, irq_n;
  int          fails = 0;
  int          n_checks = 0;
  int          n_strobe = 0;
  logic [15:0] syl_t [8] = '{16'h0200, 16'h0300, 16'h0400, 16'h0600,
                             16'h0800, 16'h0C00, 16'h1000, 16'h1800};
  logic [15:0] est_t [8] = '{16'h0010, 16'h0018, 16'h0020, 16'h0030,
                             16'h0040, 16'h0060, 16'h0080, 16'h00C0};
  logic [15:0] max_t [4] = '{16'h2800, 16'h1400, 16'h0A00, 16'h0500};
  logic [15:0] ztc_t [4] = '{16'h0000, 16'h000F, 16'h0019, 16'h002D};
  logic [7:0]  inj_t [3] = '{8'hA5, 8'h3C, 8'h0F};

  aec_host_model u_host (.clk_in(clk_in), .bclk_out(bclk), .bsel_n_out(bsel_n), .bdat_out(bdat));
  aec_top u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .bus_clk_in(bclk), .bus_sel_n_in(bsel_n),
    .bus_data_in(bdat), .bit_tick_in(tick), .adm_bit_in(adm_bit), .adm_decode_in(dec),
    .idle_enhance_in(enh), .inject_irq_en_in(irq_en), .sample_valid_in(sv), .sample_in(smp),
    .syllabic_n_out(syl_n), .max_step_out(mx), .min_step_out(mn), .run_len_out(run),
    .estimator_n_out(est_n), .second_order_out(so), .second_order_shift_out(shf),
    .zero_en_out(zen), .zero_tc_out(ztc), .half_rate_zero_out(hrz),
    .voice_threshold_out(vth), .dac_direct_out(dac), .dac_direct_strobe_out(dstb),
    .step_out(stp), .enc_sum_out(sum), .enc_sum_valid_out(sumv),
    .offset_estimate_out(est), .inject_bit_out(ibit), .inject_valid_out(ival),
    .inject_ready_out(irdy), .irq_n_out(irq_n));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic step_clk(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic pulse_tick(input logic b);
    adm_bit = b;
    tick = 1'b1;
    step_clk(1);
    tick = 1'b0;
    step_clk(3);
  endtask
  task automatic feed(input logic [15:0] v, input logic [15:0] exp);
    smp = v;
    sv = 1'b1;
    step_clk(1);
    sv = 1'b0;
    step_clk(1);
    chk(sum, exp, "encoder sum");
    step_clk(2);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // one strobe per dac write; other registers must not pulse it
  always @(posedge clk_in) begin
    if (dstb === 1'b1) n_strobe++;
  end
  // generous bound: the full sequence needs about 5300 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    finish_test();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [2:0] c;
    {nrst_in, tick, adm_bit, dec, enh, irq_en, sv, smp} = '0;
    repeat (4) @(posedge clk_in);
    #2;
    nrst_in = 1'b1;
    step_clk(4);
    chk(stp, 16'h0014, "reset step");
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      u_host.write_word(ADDR_ADM_PARAMS, {c, c, c[1:0], c, c[1:0], c[1:0], 1'b0});
      chk({3'h0, syl_n}, syl_t[c], "syllabic");
      chk(mx, max_t[c[2:1]], "max step");
      chk(mn, c[0] ? 16'h000A : 16'h0014, "min step");
      chk({13'h0, run}, {13'h0, 3'h3 + {1'b0, c[1:0]}}, "run length");
      chk({8'h0, est_n}, est_t[c], "estimator");
      chk({13'h0, so, shf}, {13'h0, c[1:0] != 2'h0, c[1:0]}, "order");
      chk({9'h0, zen, ztc}, {9'h0, c[1:0] != 2'h0, ztc_t[c[1:0]][5:0]}, "zero");
    end
    u_host.write_word(ADDR_ADM_PARAMS, 16'h0006);
    chk({9'h0, zen, ztc}, 16'h0000, "zero masked in first order");
    dec = 1'b1;
    u_host.write_word(ADDR_ADM_PARAMS, 16'h0001);
    chk({15'h0, hrz}, 16'h0001, "half zero on");
    dec = 1'b0;
    step_clk(3);
    chk({15'h0, hrz}, 16'h0000, "half zero gated");
    u_host.write_word(ADDR_ADM_PARAMS, 16'h0000);
    u_host.write_word(ADDR_VOICE_THRESH, 16'hFFFF);
    chk({1'b0, vth}, 16'h7FFF, "threshold");
    u_host.write_word(ADDR_DAC_DIRECT, 16'h8000);
    chk(dac, 16'h8000, "dac direct");
    chk(n_strobe[15:0], 16'h0001, "dac strobe");
    feed(16'h1000, 16'h1000);
    u_host.write_word(ADDR_OFFSET_TRIM, 16'h0008);
    feed(16'h8000, 16'h8008);
    chk(est, 16'h0000, "estimate idle");
    enh = 1'b1;
    for (int k = 0; k < 4; k++) feed(16'h1000, 16'h1008 - k[15:0]);
    chk(est, 16'hFFFC, "estimate tracked");
    u_host.write_word(ADDR_OFFSET_TRIM, 16'h0000);
    feed(16'h1000, 16'h0FFC);
    chk(est, 16'hFFFC, "estimate frozen");
    chk(n_strobe[15:0], 16'h0001, "strobe only on dac");
    enh = 1'b0;
    u_host.write_word(ADDR_ADM_PARAMS, 16'h1B00);
    for (int k = 0; k < 18; k++) pulse_tick(k % 6 != 5);
    chk(stp, 16'h0014, "run too short");
    u_host.write_word(ADDR_ADM_PARAMS, 16'h1A00);
    for (int k = 0; k < 5; k++) pulse_tick(1'b1);
    chk(stp, 16'h003C, "step grown");
    for (int k = 0; k < 40; k++) pulse_tick(1'b1);
    chk(stp, 16'h0500, "step clamped");
    chk({14'h0, irdy, irq_n}, 16'h0003, "irq masked");
    irq_en = 1'b1;
    step_clk(3);
    chk({14'h0, irdy, irq_n}, 16'h0002, "irq raised");
    for (int k = 0; k < 3; k++) u_host.write_byte(ADDR_ADM_INJECT, inj_t[k]);
    u_host.write_byte(ADDR_ADM_INJECT, 8'hFF);
    chk({14'h0, irdy, irq_n}, 16'h0001, "buffer full");
    for (int k = 0; k < 24; k++) begin
      pulse_tick(1'b0);
      chk({14'h0, ival, ibit}, {15'h0001, inj_t[k/8][7-k%8]}, "inject bit");
    end
    pulse_tick(1'b0);
    chk({15'h0, ival}, 16'h0000, "inject empty");
    chk({14'h0, irdy, irq_n}, 16'h0002, "reload request");
    irq_en = 1'b0;
    step_clk(3);
    chk({14'h0, irdy, irq_n}, 16'h0003, "reload masked");
    finish_test();
  end
endmodule // aec_top_tb_top
